// [rtl/esq_pkg.sv]
// Package for the encoder statistics and quantizer table register bank.
// Assumes a single 100 MHz system clock and an indirect index/data host port.
package esq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Indirect register indices
  localparam logic [9:0] IDX_WCNT_HI   = 10'h083;
  localparam logic [9:0] IDX_LUMA_SUM  = 10'h0AA;
  localparam logic [9:0] IDX_CB_SUM    = 10'h0AB;
  localparam logic [9:0] IDX_CR_SUM    = 10'h0AC;
  localparam logic [9:0] IDX_LUMA_MIN  = 10'h0AD;
  localparam logic [9:0] IDX_LUMA_MAX  = 10'h0AE;
  localparam logic [9:0] IDX_CB_MIN    = 10'h0AF;
  localparam logic [9:0] IDX_CB_MAX    = 10'h0B0;
  localparam logic [9:0] IDX_CR_MIN    = 10'h0B1;
  localparam logic [9:0] IDX_CR_MAX    = 10'h0B2;
  localparam logic [9:0] IDX_WCNT_LO   = 10'h0B4;
  localparam logic [9:0] IDX_QTAB_BASE = 10'h100;
  localparam logic [9:0] IDX_QTAB_LAST = 10'h153;
  localparam int         QTAB_DEPTH    = 84;
  localparam int         QTAB_AW       = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Field layouts and reset values
  localparam int          WCNT_W       = 20;
  localparam int          WCNT_HI_LSB  = 4;
  localparam int          WCNT_LO_W    = 4;
  localparam logic [19:0] WCNT_RESET   = 20'h00000;
  localparam logic [15:0] MIN_START    = 16'hFFFF;
  localparam logic [15:0] MAX_START    = 16'h0000;
  localparam int          STEP_INT_W   = 8;
  localparam int          STEP_FRAC_W  = 8;
  localparam int          RSTEP_INT_W  = 6;
  localparam int          RSTEP_FRAC_W = 10;
  localparam int          NUM_COMP     = 3;

  // Component codes on the pixel stream
  localparam logic [1:0] COMP_LUMA = 2'h0;
  localparam logic [1:0] COMP_CB   = 2'h1;
  localparam logic [1:0] COMP_CR   = 2'h2;

  // Host access bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [9:0]  idx;
    logic [15:0] wdata;
  } esq_host_req_s;

  // One quantizer table entry pair as seen by the quantizer
  typedef struct packed {
    logic [15:0] reciprocal_quantizer_step;
    logic [15:0] quantizer_step;
  } esq_qpair_s;

endpackage : esq_pkg

// [rtl/esq_qtab_mem.sv]
// Quantizer step table storage, 84 entries of 16 bits.
// Assumes one writer and two registered read ports on the same clock.
`timescale 1ns/1ps
module esq_qtab_mem (
  input  wire logic                       sys_clk_in,
  input  wire logic                       wr_en_in,
  input  wire logic [esq_pkg::QTAB_AW-1:0] wr_addr_in,
  input  wire logic [15:0]                wr_data_in,
  input  wire logic [esq_pkg::QTAB_AW-1:0] rd_a_addr_in,
  output logic      [15:0]                rd_a_data_out,
  input  wire logic [esq_pkg::QTAB_AW-1:0] rd_b_addr_in,
  output logic      [15:0]                rd_b_data_out
);

  // No reset: contents are undefined until the host fills them
  logic [15:0] mem_q [esq_pkg::QTAB_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read ports, host side and quantizer side
  always_ff @(posedge sys_clk_in) begin
    rd_a_data_out <= mem_q[rd_a_addr_in];
    rd_b_data_out <= mem_q[rd_b_addr_in];
  end

endmodule : esq_qtab_mem

// [rtl/esq_clk_div.sv]
// Video clock output selector: sys_clk_in divided by two or by four.
// Assumes the caller gates nothing; output comes from a flip-flop.
`timescale 1ns/1ps
module esq_clk_div (
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic half_rate_in,
  output logic      video_clock_out
);

  logic div_q;
  logic full_q;

  ////////////////////////////////////////////////////////////////////////////
  // Full rate is a toggle per edge, half rate toggles every other edge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      div_q  <= 1'b0;
      full_q <= 1'b0;
    end else begin
      full_q <= ~full_q;
      if (full_q) begin
        div_q <= ~div_q;
      end
    end
  end

  // Select registered so the output never glitches on a mode change
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      video_clock_out <= 1'b0;
    end else begin
      video_clock_out <= half_rate_in ? ~div_q : ~full_q; // [R14]
    end
  end

endmodule : esq_clk_div

// [rtl/esq_regs.sv]
// Encoder statistics and quantizer step table register bank.
// Assumes the host port, pixel stream and field strobes are synchronous to
// sys_clk_in; the video clock is modelled as this same clock.
//
// Function
// R1: Luma sum of block 39, 16-bit read-only
// R2: Blue chroma sum of block 40, read-only
// R3: Red chroma sum of block 41, read-only
// R4: Min and max of each component, six registers
// R5: Reserved bits above 16 read zero
// R6: Word count bits 19:4 high, 3:0 low
// R7: Word count double buffered, copied at field end
// R8: Word count halves read zero after reset
// R9: Table at 0x100-0x153, reciprocal even, step odd
// R10: Step entries are unsigned 8.8
// R11: Reciprocal entries are unsigned 6.10
// R12: Host computes and writes table during encode
// R13: Host assumes no reset value for statistics
// R14: Clock output full or half video rate; the code gives sys_clk_in divided by two or by four
// R15: Fresh statistics set ready flag and pin
// R16: Writes to read-only indices have no effect
// R17: Statistics registers update atomically
`timescale 1ns/1ps
module esq_regs (
  input  wire logic                        sys_clk_in,
  input  wire logic                        sys_rst_in,
  // Host indirect access
  input  wire esq_pkg::esq_host_req_s      host_req_in,
  output logic      [31:0]                 host_rdata_out,
  output logic                             host_rvalid_out,
  // Status clear by host and mode control bit
  input  wire logic                        stats_ack_in,
  input  wire logic                        clk_half_sel_in,
  // Pixel stream from the video front end
  input  wire logic                        pix_valid_in,
  input  wire logic [1:0]                  pix_comp_in,
  input  wire logic [7:0]                  pix_data_in,
  input  wire logic [5:0]                  pix_block_in,
  input  wire logic                        field_start_in,
  input  wire logic                        field_end_in,
  // Encoded word strobe from the coder
  input  wire logic                        word_out_in,
  // Quantizer lookup, statistics ready pin and video clock output
  input  wire logic [5:0]                  q_pair_sel_in,
  output esq_pkg::esq_qpair_s              q_pair_out,
  output logic                             stats_ready_out,
  output logic                             video_clock_out
);

  localparam logic [5:0] BLK_LUMA = 6'd39;
  localparam logic [5:0] BLK_CB   = 6'd40;
  localparam logic [5:0] BLK_CR   = 6'd41;

  logic [15:0] luma_block_sum_q, blue_chroma_block_sum_q, red_chroma_block_sum_q;
  logic [15:0] acc_luma_q, acc_cb_q, acc_cr_q;
  logic [15:0] min_run_q [esq_pkg::NUM_COMP];
  logic [15:0] max_run_q [esq_pkg::NUM_COMP];
  logic [15:0] min_pub_q [esq_pkg::NUM_COMP];
  logic [15:0] max_pub_q [esq_pkg::NUM_COMP];
  logic [19:0] wcnt_acc_q, wcnt_pub_q;
  logic        stats_ready_flag_q;
  logic        in_field_q;
  logic        qtab_hit;
  logic [9:0]  qtab_off;
  logic [15:0] qtab_rdata;
  logic [15:0] qstep_rd, qrstep_rd;
  logic        rd_tab_q;
  logic [15:0] rd_reg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pixel sums for the last three subband blocks, accumulated privately
  always_ff @(posedge sys_clk_in) begin
    if (field_start_in) begin
      acc_luma_q <= 16'h0000;
      acc_cb_q   <= 16'h0000;
      acc_cr_q   <= 16'h0000;
    end else if (pix_valid_in) begin
      if (pix_comp_in == esq_pkg::COMP_LUMA && pix_block_in == BLK_LUMA) begin
        acc_luma_q <= acc_luma_q + {8'h00, pix_data_in}; // [R1]
      end
      if (pix_comp_in == esq_pkg::COMP_CB && pix_block_in == BLK_CB) begin
        acc_cb_q <= acc_cb_q + {8'h00, pix_data_in}; // [R2]
      end
      if (pix_comp_in == esq_pkg::COMP_CR && pix_block_in == BLK_CR) begin
        acc_cr_q <= acc_cr_q + {8'h00, pix_data_in}; // [R3]
      end
    end
  end

  // Running min and max per component, one lane per component
  genvar gi;
  generate
    for (gi = 0; gi < esq_pkg::NUM_COMP; gi++) begin : g_minmax
      always_ff @(posedge sys_clk_in) begin
        if (field_start_in) begin
          min_run_q[gi] <= esq_pkg::MIN_START;
          max_run_q[gi] <= esq_pkg::MAX_START;
        end else if (pix_valid_in && pix_comp_in == 2'(gi)) begin
          if ({8'h00, pix_data_in} < min_run_q[gi]) begin
            min_run_q[gi] <= {8'h00, pix_data_in}; // [R4]
          end
          if ({8'h00, pix_data_in} > max_run_q[gi]) begin
            max_run_q[gi] <= {8'h00, pix_data_in}; // [R4]
          end
        end
      end
      // Published copy changes only at field end, whole words at once
      always_ff @(posedge sys_clk_in) begin
        if (field_end_in) begin
          min_pub_q[gi] <= min_run_q[gi]; // [R17]
          max_pub_q[gi] <= max_run_q[gi]; // [R17]
        end
      end
    end
  endgenerate

  // Host visible sums load in one edge, so no torn reads
  always_ff @(posedge sys_clk_in) begin
    if (field_end_in) begin
      luma_block_sum_q        <= acc_luma_q; // [R17]
      blue_chroma_block_sum_q <= acc_cb_q;
      red_chroma_block_sum_q  <= acc_cr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoded word count, double buffered
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      in_field_q <= 1'b0;
    end else if (field_start_in) begin
      in_field_q <= 1'b1;
    end else if (field_end_in) begin
      in_field_q <= 1'b0;
    end
  end

  // Stray word strobes between fields are not counted
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || field_start_in) begin
      wcnt_acc_q <= esq_pkg::WCNT_RESET;
    end else if (word_out_in && in_field_q) begin
      wcnt_acc_q <= wcnt_acc_q + 20'h00001; // [R6]
    end
  end

  // Published count only moves at reset and at field end
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wcnt_pub_q <= esq_pkg::WCNT_RESET; // [R8]
    end else if (field_end_in) begin
      wcnt_pub_q <= wcnt_acc_q; // [R7]
    end
  end

  // Ready flag: set wins over the host clear
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      stats_ready_flag_q <= 1'b0;
    end else if (field_end_in) begin
      stats_ready_flag_q <= 1'b1; // [R15]
    end else if (stats_ack_in) begin
      stats_ready_flag_q <= 1'b0;
    end
  end
  assign stats_ready_out = stats_ready_flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Quantizer table: only its indices accept writes
  assign qtab_hit = host_req_in.idx >= esq_pkg::IDX_QTAB_BASE &&
                    host_req_in.idx <= esq_pkg::IDX_QTAB_LAST; // [R9]
  assign qtab_off = host_req_in.idx - esq_pkg::IDX_QTAB_BASE;

  esq_qtab_mem u_qtab (
    .sys_clk_in    (sys_clk_in),
    .wr_en_in      (host_req_in.wr && qtab_hit), // [R16]
    .wr_addr_in    (qtab_off[esq_pkg::QTAB_AW-1:0]),
    .wr_data_in    (host_req_in.wdata),
    .rd_a_addr_in  (qtab_off[esq_pkg::QTAB_AW-1:0]),
    .rd_a_data_out (qtab_rdata),
    .rd_b_addr_in  ({q_pair_sel_in, 1'b0}),
    .rd_b_data_out (qrstep_rd)
  );

  // Second copy for the odd entry keeps the pair read single-cycle
  esq_qtab_mem u_qtab_odd (
    .sys_clk_in    (sys_clk_in),
    .wr_en_in      (host_req_in.wr && qtab_hit),
    .wr_addr_in    (qtab_off[esq_pkg::QTAB_AW-1:0]),
    .wr_data_in    (host_req_in.wdata),
    .rd_a_addr_in  ({q_pair_sel_in, 1'b1}),
    .rd_a_data_out (qstep_rd),
    .rd_b_addr_in  ({q_pair_sel_in, 1'b1}),
    .rd_b_data_out ()
  );

  // Even entry is 6.10 reciprocal, odd entry is 8.8 step
  assign q_pair_out.reciprocal_quantizer_step = qrstep_rd; // [R11]
  assign q_pair_out.quantizer_step            = qstep_rd;  // [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux, one cycle of latency
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rd_reg_q        <= 16'h0000;
      rd_tab_q        <= 1'b0;
      host_rvalid_out <= 1'b0;
    end else begin
      host_rvalid_out <= host_req_in.rd;
      rd_tab_q        <= qtab_hit;
      unique case (host_req_in.idx)
        esq_pkg::IDX_LUMA_SUM: rd_reg_q <= luma_block_sum_q;
        esq_pkg::IDX_CB_SUM:   rd_reg_q <= blue_chroma_block_sum_q;
        esq_pkg::IDX_CR_SUM:   rd_reg_q <= red_chroma_block_sum_q;
        esq_pkg::IDX_LUMA_MIN: rd_reg_q <= min_pub_q[0];
        esq_pkg::IDX_LUMA_MAX: rd_reg_q <= max_pub_q[0];
        esq_pkg::IDX_CB_MIN:   rd_reg_q <= min_pub_q[1];
        esq_pkg::IDX_CB_MAX:   rd_reg_q <= max_pub_q[1];
        esq_pkg::IDX_CR_MIN:   rd_reg_q <= min_pub_q[2];
        esq_pkg::IDX_CR_MAX:   rd_reg_q <= max_pub_q[2];
        esq_pkg::IDX_WCNT_HI:  rd_reg_q <= wcnt_pub_q[19:4]; // [R6]
        esq_pkg::IDX_WCNT_LO:  rd_reg_q <= {12'h000, wcnt_pub_q[3:0]}; // [R6]
        default:               rd_reg_q <= 16'h0000;
      endcase
    end
  end

  // Upper half always zero
  assign host_rdata_out = {16'h0000, rd_tab_q ? qtab_rdata : rd_reg_q}; // [R5]

  ////////////////////////////////////////////////////////////////////////////
  // Clock output
  esq_clk_div u_clk (
    .sys_clk_in      (sys_clk_in),
    .sys_rst_in      (sys_rst_in),
    .half_rate_in    (clk_half_sel_in),
    .video_clock_out (video_clock_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rsvd_zero;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      host_rvalid_out |-> host_rdata_out[31:16] == 16'h0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // [R5]

  property p_wcnt_hold;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !field_end_in |=> wcnt_pub_q == $past(wcnt_pub_q);
  endproperty
  a_wcnt_hold: assert property (p_wcnt_hold) else $error("count moved mid field"); // [R7]

  property p_wcnt_copy;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      field_end_in |=> wcnt_pub_q == $past(wcnt_acc_q);
  endproperty
  a_wcnt_copy: assert property (p_wcnt_copy) else $error("count not copied"); // [R7]

  property p_wcnt_reset;
    @(posedge sys_clk_in) $fell(sys_rst_in) |-> wcnt_pub_q == 20'h00000;
  endproperty
  a_wcnt_reset: assert property (p_wcnt_reset) else $error("count not zero"); // [R8]

  property p_ready_set;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      field_end_in |=> stats_ready_out;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set"); // [R15]

  property p_sum_stable;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !field_end_in |=> $stable(luma_block_sum_q);
  endproperty
  a_sum_stable: assert property (p_sum_stable) else $error("sum torn"); // [R17]

  property p_hi_read;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      host_req_in.rd && host_req_in.idx == esq_pkg::IDX_WCNT_HI && !field_end_in
      |=> host_rdata_out[15:0] == wcnt_pub_q[19:4];
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high count wrong"); // [R6]

  property p_minmax_order;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      pix_valid_in && pix_comp_in == esq_pkg::COMP_LUMA && !field_start_in
      |=> min_run_q[0] <= max_run_q[0];
  endproperty
  a_minmax_order: assert property (p_minmax_order) else $error("min above max"); // [R4]

  property p_acc_clear;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      field_start_in |=> acc_luma_q == 16'h0000 && acc_cb_q == 16'h0000 && acc_cr_q == 16'h0000;
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("sums not cleared"); // [R1]

  property p_sum_copy;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      field_end_in |=> luma_block_sum_q == $past(acc_luma_q);
  endproperty
  a_sum_copy: assert property (p_sum_copy) else $error("luma sum not copied"); // [R1]

  property p_cb_copy;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      field_end_in |=> blue_chroma_block_sum_q == $past(acc_cb_q);
  endproperty
  a_cb_copy: assert property (p_cb_copy) else $error("blue sum not copied"); // [R2]

  property p_cr_copy;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      field_end_in |=> red_chroma_block_sum_q == $past(acc_cr_q);
  endproperty
  a_cr_copy: assert property (p_cr_copy) else $error("red sum not copied"); // [R3]

  property p_min_stable;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !field_end_in |=> $stable(min_pub_q[0]) && $stable(min_pub_q[1]) && $stable(min_pub_q[2]);
  endproperty
  a_min_stable: assert property (p_min_stable) else $error("minimum torn"); // [R17]

  property p_max_stable;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !field_end_in |=> $stable(max_pub_q[0]) && $stable(max_pub_q[1]) && $stable(max_pub_q[2]);
  endproperty
  a_max_stable: assert property (p_max_stable) else $error("maximum torn"); // [R17]

  property p_ready_clear;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      stats_ack_in && !field_end_in |=> !stats_ready_out;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared"); // [R15]

  property p_lo_read;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      host_req_in.rd && host_req_in.idx == esq_pkg::IDX_WCNT_LO && !field_end_in
      |=> host_rdata_out == {28'h0000000, wcnt_pub_q[3:0]};
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("low count wrong"); // [R6]

  property p_clk_full;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
      !clk_half_sel_in && !$past(clk_half_sel_in) |=> video_clock_out != $past(video_clock_out);
  endproperty
  a_clk_full: assert property (p_clk_full) else $error("clock out not toggling"); // [R14]

endmodule : esq_regs

// [verif/esq_host_model.sv]
// Host processor model for the indirect index and data port of the bank.
// Assumes the bank answers a read one cycle after the request edge.
`timescale 1ns/1ps
module esq_host_model (
  input  wire logic              sys_clk_in,
  output esq_pkg::esq_host_req_s host_req_out,
  input  wire logic [31:0]       host_rdata_in,
  input  wire logic              host_rvalid_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Quiet bus at time zero
  initial host_req_out = '0;

  // One-cycle write pulse; table values are worked out by the bench
  // Released fields are inverted so no stale index lingers on the bus
  task automatic host_write(input logic [9:0] idx, input logic [15:0] wdata);
    @(posedge sys_clk_in);
    host_req_out <= '{rd: 1'b0, wr: 1'b1, idx: idx, wdata: wdata};
    @(posedge sys_clk_in);
    host_req_out <= '{rd: 1'b0, wr: 1'b0, idx: ~idx, wdata: ~wdata};
  endtask : host_write

  // Data is taken at the answer edge; a missing answer reads unknown
  // Callers read statistics after a field end, except the word count reads after reset and mid field
  task automatic host_read(input logic [9:0] idx, output logic [31:0] rdata);
    @(posedge sys_clk_in);
    host_req_out <= '{rd: 1'b1, wr: 1'b0, idx: idx, wdata: 16'h0000};
    @(posedge sys_clk_in);
    host_req_out <= '{rd: 1'b0, wr: 1'b0, idx: ~idx, wdata: 16'hFFFF};
    @(posedge sys_clk_in);
    rdata = (host_rvalid_in === 1'b1) ? host_rdata_in : 'x;
  endtask : host_read
endmodule : esq_host_model

// [verif/tb_top.sv]
// Self-checking bench for the statistics and quantizer table bank.
// Assumes esq_host_model as the host and one 100 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic                   sys_clk_in      = 1'b0;
  logic                   sys_rst_in      = 1'b1;
  esq_pkg::esq_host_req_s host_req;
  logic [31:0]            host_rdata;
  logic                   host_rvalid;
  logic                   stats_ack_in    = 1'b0;
  logic                   clk_half_sel_in = 1'b0;
  logic                   pix_valid_in    = 1'b0;
  logic [1:0]             pix_comp_in     = 2'h0;
  logic [7:0]             pix_data_in     = 8'h00;
  logic [5:0]             pix_block_in    = 6'h00;
  logic                   field_start_in  = 1'b0;
  logic                   field_end_in    = 1'b0;
  logic                   word_out_in     = 1'b0;
  logic [5:0]             q_pair_sel_in   = 6'h00;
  esq_pkg::esq_qpair_s    q_pair;
  logic                   stats_ready;
  logic                   video_clock;
  logic [15:0]            e_sum [3];
  logic [15:0]            e_min [3];
  logic [15:0]            e_max [3];
  logic [19:0]            e_cnt           = 20'h00000;
  logic [19:0]            p_cnt;
  logic [15:0]            qtab [84];
  logic [31:0]            seed            = 32'h7AB1A8B1;
  logic [31:0]            rd;
  logic [31:0]            n;
  logic                   prev;
  int                     errors          = 0;
  int                     samples_checked = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  ////////////////////////////////////////////////////////////////////////////
  // Device under test and its host
  esq_regs esq_regs_inst (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .host_req_in(host_req),
    .host_rdata_out(host_rdata), .host_rvalid_out(host_rvalid),
    .stats_ack_in(stats_ack_in), .clk_half_sel_in(clk_half_sel_in),
    .pix_valid_in(pix_valid_in), .pix_comp_in(pix_comp_in), .pix_data_in(pix_data_in),
    .pix_block_in(pix_block_in), .field_start_in(field_start_in),
    .field_end_in(field_end_in), .word_out_in(word_out_in),
    .q_pair_sel_in(q_pair_sel_in), .q_pair_out(q_pair),
    .stats_ready_out(stats_ready), .video_clock_out(video_clock)
  );
  esq_host_model esq_host_model_inst (
    .sys_clk_in(sys_clk_in), .host_req_out(host_req),
    .host_rdata_in(host_rdata), .host_rvalid_in(host_rvalid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xrand

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    esq_host_model_inst.host_read(idx, rd);
    chk_word($sformatf("index %0h", idx), exp, rd);
  endtask : rd_chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // One field of random pixels; about half land outside the summed block
  // of their component, which the sums must skip and the extremes must see
  task automatic run_field(input int npix, input bit mid);
    logic [31:0] r;
    logic [1:0]  c;
    logic [7:0]  d;
    logic [5:0]  b;
    p_cnt = e_cnt;
    e_cnt = 20'h00000;
    for (int k = 0; k < 3; k++) begin
      e_sum[k] = 16'h0000;
      e_min[k] = esq_pkg::MIN_START;
      e_max[k] = esq_pkg::MAX_START;
    end
    @(posedge sys_clk_in) field_start_in <= 1'b1;
    @(posedge sys_clk_in) field_start_in <= 1'b0;
    fork
      for (int i = 0; i < npix; i++) begin
        r = xrand();
        c = (r[9:8] == 2'h3) ? 2'h0 : r[9:8];
        d = (r[15:13] == 3'h0) ? 8'h00 : (r[15:13] == 3'h1) ? 8'hFF : r[23:16];
        b = r[4] ? 6'h27 + 6'(c) : r[29:24];
        @(posedge sys_clk_in);
        pix_valid_in <= r[0] | r[1];
        pix_comp_in  <= c;
        pix_block_in <= b;
        pix_data_in  <= d;
        word_out_in  <= r[2] & r[3];
        if (r[0] | r[1]) begin
          if (b == 6'h27 + 6'(c)) e_sum[c] = e_sum[c] + 16'(d);
          if (16'(d) < e_min[c]) e_min[c] = 16'(d);
          if (16'(d) > e_max[c]) e_max[c] = 16'(d);
        end
        if (r[2] & r[3]) e_cnt = e_cnt + 20'h00001;
      end
      if (mid) begin
        repeat (60) @(posedge sys_clk_in);
        rd_chk(esq_pkg::IDX_WCNT_HI, {16'h0000, p_cnt[19:4]});
        rd_chk(esq_pkg::IDX_WCNT_LO, {28'h0000000, p_cnt[3:0]});
      end
    join
    @(posedge sys_clk_in);
    pix_valid_in <= 1'b0;
    word_out_in  <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    @(posedge sys_clk_in) begin
      field_end_in <= 1'b1;
      stats_ack_in <= mid; // Clear in the same cycle loses to the set
    end
    @(posedge sys_clk_in) begin
      field_end_in <= 1'b0;
      stats_ack_in <= 1'b0;
    end
    repeat (2) @(posedge sys_clk_in);
    chk_flag("stats_ready", 1'b1, stats_ready);
  endtask : run_field

  // Reads every statistic; with poke set, writes each read-only index too
  task automatic check_regs(input bit poke);
    logic [9:0]  idx [11];
    logic [31:0] ev  [11];
    idx = '{esq_pkg::IDX_LUMA_SUM, esq_pkg::IDX_CB_SUM, esq_pkg::IDX_CR_SUM,
            esq_pkg::IDX_LUMA_MIN, esq_pkg::IDX_LUMA_MAX, esq_pkg::IDX_CB_MIN,
            esq_pkg::IDX_CB_MAX, esq_pkg::IDX_CR_MIN, esq_pkg::IDX_CR_MAX,
            esq_pkg::IDX_WCNT_HI, esq_pkg::IDX_WCNT_LO};
    for (int k = 0; k < 3; k++) begin
      ev[k]         = {16'h0000, e_sum[k]};
      ev[3 + 2 * k] = {16'h0000, e_min[k]};
      ev[4 + 2 * k] = {16'h0000, e_max[k]};
    end
    ev[9]  = {16'h0000, e_cnt[19:4]};
    ev[10] = {28'h0000000, e_cnt[3:0]};
    for (int k = 0; k < 11; k++) begin
      rd_chk(idx[k], ev[k]);
      if (poke) begin
        esq_host_model_inst.host_write(idx[k], 16'(xrand()));
        rd_chk(idx[k], ev[k]);
      end
    end
  endtask : check_regs

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd_chk(esq_pkg::IDX_WCNT_HI, 32'h00000000);
    rd_chk(esq_pkg::IDX_WCNT_LO, 32'h00000000);
    chk_flag("stats_ready", 1'b0, stats_ready);
    $display("test reset done");
    run_field(600, 1'b0);
    check_regs(1'b1);
    @(posedge sys_clk_in) stats_ack_in <= 1'b1;
    @(posedge sys_clk_in) stats_ack_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk_flag("stats_ready", 1'b0, stats_ready);
    run_field(2400, 1'b1);
    check_regs(1'b0);
    $display("test fields done");
    // Table with extreme values in the first pair
    for (int i = 0; i < 84; i++) begin
      qtab[i] = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'(xrand());
      esq_host_model_inst.host_write(esq_pkg::IDX_QTAB_BASE + 10'(i), qtab[i]);
    end
    for (int i = 0; i < 84; i++) begin
      rd_chk(esq_pkg::IDX_QTAB_BASE + 10'(i), {16'h0000, qtab[i]});
    end
    for (int p = 0; p < 42; p++) begin
      @(posedge sys_clk_in) q_pair_sel_in <= 6'(p);
      repeat (2) @(posedge sys_clk_in);
      chk_word("q_pair", {qtab[2 * p], qtab[2 * p + 1]}, q_pair);
    end
    esq_host_model_inst.host_write(10'h154, 16'h1234);
    esq_host_model_inst.host_write(10'h0FF, 16'h4321);
    rd_chk(10'h154, 32'h00000000);
    rd_chk(10'h3FF, 32'h00000000);
    rd_chk(esq_pkg::IDX_QTAB_LAST, {16'h0000, qtab[83]});
    rd_chk(esq_pkg::IDX_QTAB_BASE, {16'h0000, qtab[0]});
    $display("test table done");
    // Rising edges of the clock output over 40 cycles
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk_in) clk_half_sel_in <= m[0];
      repeat (8) @(posedge sys_clk_in);
      // Sampled on the falling edge, where the registered output has settled
      @(negedge sys_clk_in);
      n = 32'h00000000;
      for (int j = 0; j < 40; j++) begin
        prev = video_clock;
        @(negedge sys_clk_in);
        if (video_clock === 1'b1 && prev === 1'b0) n = n + 32'h00000001;
      end
      chk_word("clock rises", (m == 1) ? 32'h0000000A : 32'h00000014, n);
    end
    $display("test clock done");
    wrap_up();
  end

  // Whole run needs well under 15000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    errors++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : tb_top
